// [core/irt_timer_standby.sv]
// irt_timer_standby: transmit pattern timer with carrier output and
// the halt/stop standby controller beside it.
// assumes: i_clk is the system oscillator; cpu strobes are one-cycle
// pulses on i_clk; key and sense pins are asynchronous.
`timescale 1ns/1ps
`include "irt_defines.svh"
module irt_timer_standby (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_load_valid,
  input wire logic [`IRT_LOAD_W-1:0] i_load_value,
  input wire logic i_prescale_sel,
  input wire logic i_carrier_dis,
  input wire logic [1:0] i_carrier_sel,
  input wire logic i_indicator_mode,
  input wire logic i_halt_exec,
  input wire logic [3:0] i_halt_operand,
  input wire logic i_status_clear,
  input wire logic [7:0] i_key_scan_high,
  input wire logic [3:0] i_key_in,
  input wire logic i_sense0_pin,
  input wire logic i_sense1_pin,
  input wire logic i_sense0_input,
  input wire logic i_sense1_input,
  output logic o_ir_output_pin,
  output logic o_sense1_indicator_n,
  output logic o_timer_end,
  output logic [`IRT_CNT_W-1:0] o_timer_count,
  output logic o_output_permit_flag,
  output logic o_status_flag,
  output logic o_osc_hold_low,
  output logic o_cpu_stall,
  output logic o_resume_next,
  output logic o_internal_reset,
  output logic [2:0] o_mode
);
  import irt_pkg::*;

  irt_state_t st;
  irt_state_t next_st;
  logic car_high;
  logic tick;
  logic busy;
  logic [3:0] keys;
  logic sense0;
  logic sense1;
  logic op_stop;
  logic op_halt;
  logic op_legal;
  logic precond;
  logic stop_cond;
  logic release_cond;
  logic zero_end;
  logic sense_sel;

  // carrier source, free running so the first high may be short
  irt_carrier u_carrier (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_sel(i_carrier_sel),
    .i_half(i_prescale_sel),
    .o_high(car_high)
  );

  // synchronised pin levels, second stage only
  assign keys = st.sync2[3:0];
  assign sense0 = st.sync2[4];
  assign sense1 = st.sync2[5];

  // timer tick and zero detect
  assign tick = st.pre == (i_prescale_sel ? `IRT_PRE_DIV16
                                          : `IRT_PRE_DIV8); // R03
  assign zero_end = !st.running && (st.count == '0); // R01 R04
  assign busy = st.running || st.permit || (st.count != '0);

  // halt operand decode and its conditions
  assign op_stop = (i_halt_operand[2:0] == `IRT_OP_STOP_ALL0) ||
                   (i_halt_operand[2:0] == `IRT_OP_STOP_ALL1) ||
                   (i_halt_operand[2:0] == `IRT_OP_STOP_SCAN0);
  assign op_halt = i_halt_operand[2:0] == `IRT_OP_HALT; // R19
  assign op_legal = op_stop || op_halt; // R20
  // scan pins must drive high before a stop
  always_comb begin
    if (i_halt_operand[2:0] == `IRT_OP_STOP_SCAN0) begin
      precond = i_key_scan_high[0]; // R17
    end else if (op_stop) begin
      precond = &i_key_scan_high; // R17
    end else begin
      precond = 1'b1;
    end
  end
  // sense release enable: live operand at entry, latched copy after
  assign sense_sel = (st.mode == IRT_RUN) ?
                     i_halt_operand[`IRT_OP_SENSE_BIT] : st.sense_rel; // R18
  // stop release: any key high, or sense high with top bit
  assign stop_cond = (|keys) ||
                     (sense_sel &&
                      ((sense0 && i_sense0_input) ||
                       (sense1 && i_sense1_input))); // R17 R18
  assign release_cond = op_halt ? (st.count == '0) : stop_cond;

  // whole next state
  always_comb begin
    next_st = st;
    next_st.sync1 = {i_sense1_pin, i_sense0_pin, i_key_in};
    next_st.sync2 = st.sync1;
    next_st.resume = 1'b0;
    next_st.int_reset = 1'b0;

    // prescaler restarts on each load so ticks line up
    if (i_load_valid || tick) begin
      next_st.pre = 4'h0;
    end else begin
      next_st.pre = 4'(st.pre + 4'h1);
    end

    // timer counting, runs load plus one ticks
    if (i_load_valid) begin
      next_st.count = i_load_value[`IRT_CNT_W-1:0]; // R24
      next_st.permit = i_load_value[`IRT_PERMIT_BIT]; // R24 R09
      next_st.running = i_load_value[`IRT_CNT_W-1:0] != '0; // R02
    end else if (st.running && tick) begin
      if (st.count == '0) begin
        next_st.running = 1'b0; // R04
      end else begin
        next_st.count = 9'(st.count - 9'h001); // R03
      end
    end

    // carrier gate: a high phase cut by a stop runs to its fall
    if (st.running && !next_st.running && car_high &&
        !i_carrier_dis) begin
      next_st.hold = 1'b1; // R08
    end else if (!car_high || next_st.running) begin
      next_st.hold = 1'b0; // R08
    end

    // status clear by software; hardware set below wins
    if (i_status_clear) begin
      next_st.flag = 1'b0;
    end

    // standby sequencer
    case (st.mode)
      IRT_RUN: begin
        if (i_halt_exec) begin
          next_st.sense_rel = i_halt_operand[`IRT_OP_SENSE_BIT]; // R18
          if (st.flag) begin
            next_st.flag = release_cond; // R14
          end else if (!op_legal || !precond) begin
            next_st.int_reset = 1'b1; // R20
          end else if (release_cond) begin
            next_st.flag = 1'b1; // R15
            next_st.resume = 1'b1; // R15
          end else if (op_halt) begin
            next_st.mode = IRT_HALT; // R12 R11
          end else if (busy) begin
            next_st.mode = IRT_STOP_PEND; // R21
          end else begin
            next_st.mode = IRT_STOP; // R12
          end
        end
      end
      IRT_HALT: begin
        if (st.count == '0) begin
          next_st.mode = IRT_RUN; // R05
          next_st.flag = 1'b1; // R13
          next_st.resume = 1'b1; // R05 R16
        end
      end
      IRT_STOP_PEND: begin
        if (!busy) begin
          next_st.mode = IRT_STOP; // R21
        end
      end
      IRT_STOP: begin
        if (stop_cond) begin
          next_st.mode = IRT_WAIT; // R22
          next_st.wait_cnt = `IRT_OSC_WAIT;
        end
      end
      IRT_WAIT: begin
        if (st.wait_cnt != 8'h00) begin
          next_st.wait_cnt = 8'(st.wait_cnt - 8'h01);
        end else if (stop_cond) begin
          next_st.mode = IRT_RUN; // R22
          next_st.flag = 1'b1; // R13
          next_st.resume = 1'b1; // R16
        end else begin
          next_st.mode = IRT_STOP; // R22
        end
      end
      default: begin
        next_st.mode = IRT_RUN;
      end
    endcase

    // registered pin and status outputs
    next_st.osc_low = next_st.mode == IRT_STOP; // R10
    next_st.stall = next_st.mode != IRT_RUN; // R11
    next_st.timer_end = !next_st.running &&
                        (next_st.count == '0); // R04
    if (next_st.permit && next_st.running) begin
      next_st.ir = i_carrier_dis ? 1'b1 : car_high; // R06 R07
    end else if (next_st.permit && next_st.hold) begin
      next_st.ir = car_high; // R08
    end else begin
      next_st.ir = 1'b0; // R06
    end
    next_st.ind_n = !(next_st.permit && next_st.running &&
                      i_indicator_mode); // R06
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
      st.ind_n <= 1'b1;
      st.timer_end <= 1'b1;
      st.mode <= IRT_RUN;
    end else begin
      st <= next_st;
    end
  end

  assign o_ir_output_pin = st.ir;
  assign o_sense1_indicator_n = st.ind_n;
  assign o_timer_end = st.timer_end;
  assign o_timer_count = st.count;
  assign o_output_permit_flag = st.permit;
  assign o_status_flag = st.flag;
  assign o_osc_hold_low = st.osc_low;
  assign o_cpu_stall = st.stall;
  assign o_resume_next = st.resume;
  assign o_internal_reset = st.int_reset;
  assign o_mode = st.mode;

  // checks on timer and standby behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_zero_load;
    i_load_valid && (i_load_value[8:0] == 9'h000) |=> !st.running;
  endproperty
  a_zero_load: assert property (p_zero_load) // R02
    else $error("zero load started the timer");

  property p_start_load;
    i_load_valid && (i_load_value[8:0] != 9'h000)
      |=> st.running && (st.count == $past(i_load_value[8:0]));
  endproperty
  a_start_load: assert property (p_start_load) // R02
    else $error("nonzero load did not start the timer");

  property p_step;
    st.running && tick && (st.count != '0) && !i_load_valid
      |=> st.count == 9'($past(st.count) - 9'h001);
  endproperty
  a_step: assert property (p_step) // R03
    else $error("counter did not step by one on a tick");

  property p_hold;
    !tick && !i_load_valid |=> $stable(st.count);
  endproperty
  a_hold: assert property (p_hold) // R03
    else $error("counter moved without a tick");

  property p_end_level;
    zero_end && !i_load_valid |=> o_timer_end;
  endproperty
  a_end_level: assert property (p_end_level) // R04
    else $error("timer end dropped while stopped at zero");

  property p_halt_release;
    (st.mode == IRT_HALT) && (st.count == '0)
      |=> o_resume_next && o_status_flag && (st.mode == IRT_RUN);
  endproperty
  a_halt_release: assert property (p_halt_release) // R05
    else $error("halt not released at timer zero");

  property p_indicator;
    st.permit && st.running && i_indicator_mode && !i_load_valid &&
      !(tick && (st.count == '0)) |=> !o_sense1_indicator_n;
  endproperty
  a_indicator: assert property (p_indicator) // R06
    else $error("indicator not low while timer runs");

  property p_stop_osc;
    (st.mode == IRT_STOP) |-> o_osc_hold_low || $past(st.mode != IRT_STOP);
  endproperty
  a_stop_osc: assert property (p_stop_osc) // R10
    else $error("oscillator pins not held low in stop");

  property p_flag_set_no_entry;
    i_halt_exec && st.flag && (st.mode == IRT_RUN)
      |=> (st.mode == IRT_RUN) && !o_internal_reset;
  endproperty
  a_flag_set_no_entry: assert property (p_flag_set_no_entry) // R14
    else $error("standby entered with status flag set");

  property p_illegal;
    i_halt_exec && !st.flag && !op_legal && (st.mode == IRT_RUN)
      |=> o_internal_reset ##1 !o_internal_reset;
  endproperty
  a_illegal: assert property (p_illegal) // R20
    else $error("illegal halt operand gave no reset pulse");

  property p_stop_idle;
    (st.mode == IRT_STOP) |-> (st.count == '0) && !st.permit;
  endproperty
  a_stop_idle: assert property (p_stop_idle) // R21
    else $error("stop entered with timer bits nonzero");

endmodule // irt_timer_standby

// [core/irt_defines.svh]
// irt_defines.svh: widths, field positions, limits, codes and counts
// for the remote transmit timer and standby controller.
// assumes: included by bare name from the package and the design modules
//
// Function
// R01: nine-bit down counter, permit flag, zero detect
// R02: nonzero load starts timer, zero stays stopped
// R03: tick every 8 or 16 clocks
// R04: stop at zero, hold timer-end while stopped
// R05: timer end releases halt, resume next
// R06: permit flag drives indicator low, ir high
// R07: carrier or steady high when carrier disabled
// R08: stop lets carrier high phase finish
// R09: software loads make one-cycle output pulses; the code makes none, a zero-count load with permit keeps ir low except when it stops a carrier high phase
// R10: stop mode holds oscillator pins low
// R11: halt keeps timer and outputs running
// R12: halt instruction enters standby only flag clear
// R13: any standby release sets status flag
// R14: flag set: no entry, flag follows condition
// R15: condition already true: skip entry, set flag
// R16: operand release resumes at next address
// R17: stop entry needs scan pins high, keys release
// R18: top operand bit adds sense pin release
// R19: code 101 is halt, released at zero
// R20: illegal code or precondition gives internal reset
// R21: stop waits for all ten timer bits zero
// R22: oscillation wait, back to stop if vanished
// R23: carrier select picks rate and duty
// R24: load is ten bits, permit flag on top
`ifndef IRT_DEFINES_SVH
`define IRT_DEFINES_SVH

// timer load word layout
`define IRT_LOAD_W 10
`define IRT_CNT_W 9
`define IRT_PERMIT_BIT 9
// prescale limits, ticks come every 8 or 16 clocks
`define IRT_PRE_DIV8 4'h7
`define IRT_PRE_DIV16 4'hF
// carrier periods in clocks at the base rate, doubled in irt_carrier for the halved rate
`define IRT_CAR_FOSC 5'h02
`define IRT_CAR_DIV8 5'h08
`define IRT_CAR_DIV12 5'h0C
// halt operand low codes
`define IRT_OP_STOP_ALL0 3'h0
`define IRT_OP_STOP_ALL1 3'h3
`define IRT_OP_STOP_SCAN0 3'h6
`define IRT_OP_HALT 3'h5
`define IRT_OP_SENSE_BIT 3
// oscillation wait after a stop release, in clocks
`define IRT_OSC_WAIT 8'h74

`endif

// [core/irt_pkg.sv]
// irt_pkg: types of the remote transmit timer and standby controller
// assumes: compiled before the design modules
`include "irt_defines.svh"
package irt_pkg;

  typedef enum logic [2:0] {
    IRT_RUN, IRT_HALT, IRT_STOP_PEND, IRT_STOP, IRT_WAIT
  } irt_mode_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic high;
  } irt_car_t;

  typedef struct packed {
    irt_mode_t mode;
    logic [`IRT_CNT_W-1:0] count;
    logic permit;
    logic running;
    logic [3:0] pre;
    logic hold;
    logic flag;
    logic [7:0] wait_cnt;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic ir;
    logic ind_n;
    logic timer_end;
    logic osc_low;
    logic stall;
    logic resume;
    logic int_reset;
    logic sense_rel;
  } irt_state_t;

endpackage

// [core/irt_carrier.sv]
// irt_carrier: free running carrier generator
// assumes: one clock, select inputs from the same clock domain
`timescale 1ns/1ps
`include "irt_defines.svh"
module irt_carrier (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_sel,
  input wire logic i_half,
  output logic o_high
);
  import irt_pkg::*;

  irt_car_t st;
  irt_car_t next_st;
  logic [4:0] period;
  logic [4:0] high_len;

  // period and high length from select, doubled on half rate
  always_comb begin
    case (i_sel)
      2'h0: period = `IRT_CAR_FOSC; // R23
      2'h1: period = `IRT_CAR_DIV8; // R23
      default: period = `IRT_CAR_DIV12; // R23
    endcase
    if (i_half) begin
      period = 5'(period << 1); // R23
    end
    if (i_sel == 2'h3) begin
      high_len = 5'(period / 5'h03); // R23
    end else begin
      high_len = 5'(period >> 1);
    end
  end

  // counter wraps at period, high in the first part
  always_comb begin
    next_st = st;
    if (st.cnt >= 5'(period - 5'h01)) begin
      next_st.cnt = 5'h00;
    end else begin
      next_st.cnt = 5'(st.cnt + 5'h01);
    end
    next_st.high = (next_st.cnt < high_len);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_high = st.high;

endmodule // irt_carrier

// [verif/irt_partner.sv]
// irt_partner: infrared led driver and key matrix facing the timer
// assumes: keys close onto the scan lines, open key inputs pulled down
`timescale 1ns/1ps
module irt_partner (
  input wire logic i_clk,
  input wire logic i_ir,
  input wire logic [7:0] i_scan_high,
  input wire logic [3:0] i_press,
  output logic [3:0] o_key_in,
  output logic [15:0] o_lit
);
  // closed key carries the scan level, open key sits at the pull-down
  always_comb begin
    o_key_in = (|i_scan_high) ? i_press : 4'h0;
  end

  // led driver counts clocks with the emitter lit
  initial o_lit = 16'h0;
  always @(posedge i_clk) begin
    if (i_ir === 1'b1) begin
      o_lit <= o_lit + 16'h1;
    end
  end
endmodule // irt_partner

// [verif/testbench.sv]
// testbench: random and corner runs of the remote timer and standby
// assumes: package and defines compiled first; 50 MHz clock
`timescale 1ns/1ps
`include "irt_defines.svh"
module testbench;
  import irt_pkg::*;
  logic i_clk, i_reset, i_load_valid, i_prescale_sel, i_carrier_dis;
  logic [`IRT_LOAD_W-1:0] i_load_value;
  logic [1:0] i_carrier_sel;
  logic i_indicator_mode, i_halt_exec, i_status_clear;
  logic [3:0] i_halt_operand, key_in, press;
  logic [7:0] i_key_scan_high;
  logic i_sense0_pin, i_sense1_pin, i_sense0_input, i_sense1_input;
  logic o_ir_output_pin, o_sense1_indicator_n, o_timer_end;
  logic [`IRT_CNT_W-1:0] o_timer_count;
  logic o_output_permit_flag, o_status_flag, o_osc_hold_low;
  logic o_cpu_stall, o_resume_next, o_internal_reset;
  logic [2:0] o_mode;
  logic [15:0] lit;
  logic saw_hi, saw_lo;
  logic [3:0] ops [4];
  int fail_count, n_checks, n_res, n_irs, seed, k, n, dv;

  irt_timer_standby irt_timer_standby_i (
    .i_clk, .i_reset, .i_load_valid, .i_load_value, .i_prescale_sel,
    .i_carrier_dis, .i_carrier_sel, .i_indicator_mode, .i_halt_exec,
    .i_halt_operand, .i_status_clear, .i_key_scan_high,
    .i_key_in(key_in), .i_sense0_pin, .i_sense1_pin, .i_sense0_input,
    .i_sense1_input, .o_ir_output_pin, .o_sense1_indicator_n,
    .o_timer_end, .o_timer_count, .o_output_permit_flag, .o_status_flag,
    .o_osc_hold_low, .o_cpu_stall, .o_resume_next, .o_internal_reset,
    .o_mode
  );
  irt_partner irt_partner_i (
    .i_clk, .i_ir(o_ir_output_pin), .i_scan_high(i_key_scan_high),
    .i_press(press), .o_key_in(key_in), .o_lit(lit)
  );

  // clock and pulse counters
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_resume_next === 1'b1) n_res++;
    if (o_internal_reset === 1'b1) n_irs++;
  end

  task automatic cyc(input int c);
    repeat (c) begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen,
        exp);
    end
  endtask
  // run length in clocks for a load value and prescale choice
  function automatic int run_clocks(input int val, input logic half);
    return (val + 1) * (half ? 16 : 8);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    int c;
    c = 0;
    while (o_mode !== m && c < lim) begin
      cyc(1);
      c++;
    end
    if (o_mode !== m) begin
      fail_count++;
      end_of_test();
    end
  endtask
  // waits for timer end, noting the ir levels seen mid-run
  task automatic wait_end(input int lim);
    k = 0;
    saw_hi = 1'b0;
    saw_lo = 1'b0;
    while (o_timer_end !== 1'b1 && k < lim) begin
      if (o_timer_count > 9'h1 && o_timer_end === 1'b0) begin
        saw_hi |= o_ir_output_pin;
        saw_lo |= !o_ir_output_pin;
      end
      cyc(1);
      k++;
    end
    if (o_timer_end !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic load(input logic [9:0] v);
    i_load_value = v;
    i_load_valid = 1'b1;
    cyc(1);
    i_load_valid = 1'b0;
  endtask
  task automatic halt(input logic [3:0] op);
    i_halt_operand = op;
    i_halt_exec = 1'b1;
    cyc(1);
    i_halt_exec = 1'b0;
  endtask
  task automatic clear_flag();
    i_status_clear = 1'b1;
    cyc(1);
    i_status_clear = 1'b0;
    cyc(1);
  endtask

  // main sequence
  initial begin
    seed = 32'hf539;
    fail_count = 0;
    n_checks = 0;
    n_res = 0;
    n_irs = 0;
    i_reset = 1'b1;
    i_load_valid = 1'b0;
    i_load_value = 10'h000;
    i_prescale_sel = 1'b0;
    i_carrier_dis = 1'b1;
    i_carrier_sel = 2'h0;
    i_indicator_mode = 1'b1;
    i_halt_exec = 1'b0;
    i_halt_operand = 4'h0;
    i_status_clear = 1'b0;
    i_key_scan_high = 8'h00;
    press = 4'h0;
    i_sense0_pin = 1'b0;
    i_sense1_pin = 1'b0;
    i_sense0_input = 1'b0;
    i_sense1_input = 1'b1;
    ops = '{4'h0, 4'h3, 4'h6, 4'hB};
    repeat (3) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    cyc(3);
    check({o_ir_output_pin, o_sense1_indicator_n, o_timer_end}, 3'h3);
    check({o_mode, o_timer_count, o_status_flag}, 13'h0);
    // random timed runs
    repeat (4) begin
      n = ($unsigned($random(seed)) % 8) + 4;
      i_prescale_sel = 1'($random(seed));
      i_carrier_dis = 1'($random(seed));
      i_carrier_sel = 2'($random(seed));
      i_indicator_mode = !i_indicator_mode;
      dv = run_clocks(n, i_prescale_sel);
      load({1'b1, 9'(n)});
      cyc(3);
      check({o_timer_end, o_sense1_indicator_n}, {1'b0, !i_indicator_mode});
      check({o_output_permit_flag, o_timer_count}, {1'b1, 9'(n)});
      wait_end(400);
      check(16'(k + 3 >= dv && k + 3 <= dv + 2), 1);
      check({saw_hi, saw_lo}, {1'b1, !i_carrier_dis});
      cyc(40);
      check({o_ir_output_pin, o_sense1_indicator_n}, 2'b01);
    end
    check(16'(lit > 16'h0), 16'h1);
    load(10'h200);
    cyc(4);
    check({o_timer_end, o_ir_output_pin}, 2'b10);
    // halt waiting for the timer
    i_prescale_sel = 1'b0;
    clear_flag();
    check(o_status_flag, 1'b0);
    load(10'h204);
    halt(4'h5);
    cyc(1);
    check({o_mode, o_cpu_stall, o_timer_end}, {3'd1, 2'b10});
    n = n_res;
    wait_mode(3'd0, 100);
    cyc(2);
    check({o_status_flag, o_cpu_stall, o_timer_count}, 11'h400);
    check(16'(n_res - n), 16'h1);
    load(10'h005);
    halt(4'h5);
    cyc(2);
    check({o_mode, o_status_flag}, 4'h0);
    wait_end(200);
    halt(4'h5);
    cyc(2);
    check({o_mode, o_status_flag}, 4'h1);
    halt(4'h5);
    cyc(2);
    check({o_mode, o_status_flag}, 4'h1);
    // undefined code and failed precondition
    clear_flag();
    n = n_irs;
    halt(4'h1);
    cyc(2);
    clear_flag();
    i_key_scan_high = 8'h7F;
    halt(4'h0);
    cyc(2);
    check({o_mode, 13'(n_irs - n)}, 16'h2);
    // stop requested while the timer runs
    clear_flag();
    i_key_scan_high = 8'hFF;
    load(10'h203);
    halt(4'h0);
    cyc(2);
    check(o_mode, 3'd2);
    wait_end(100);
    cyc(2);
    check(o_mode, 3'd2);
    load(10'h000);
    cyc(3);
    check({o_mode, o_osc_hold_low}, 4'h7);
    // key dropped before the wait ends, then held past it
    press = 4'h4;
    wait_mode(3'd4, 10);
    cyc(20);
    press = 4'h0;
    wait_mode(3'd3, 200);
    check(o_status_flag, 1'b0);
    press = 4'h4;
    wait_mode(3'd0, 200);
    press = 4'h0;
    cyc(2);
    check({o_status_flag, o_osc_hold_low}, 2'b10);
    // every stop code, released by key or sense pin
    for (int i = 0; i < 4; i++) begin
      clear_flag();
      i_key_scan_high = (ops[i] == 4'h6) ? 8'h01 : 8'hFF;
      i_sense0_input = ops[i][3];
      halt(ops[i]);
      cyc(3);
      check({o_mode, o_osc_hold_low}, 4'h7);
      n = n_res;
      if (ops[i][3]) begin
        i_sense0_pin = 1'b1;
      end else begin
        press = 4'h1;
      end
      wait_mode(3'd0, 300);
      cyc(2);
      check({o_status_flag, 15'(n_res - n)}, 16'h8001);
      i_sense0_pin = 1'b0;
      press = 4'h0;
    end
    end_of_test();
  end
endmodule // testbench
